// file: pmw_cfg.svh
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH
// unpacked window (one location per dword), byte offsets
`define PMW_U_C0_DATA_END 20'h3fffc
`define PMW_U_C0_PRAM_BASE 20'h40000
`define PMW_U_C0_PRAM_END 20'h4fffc
`define PMW_U_C0_PROM_BASE 20'h50000
`define PMW_U_C0_PROM_END 20'h53ffc
`define PMW_U_C1_DATA_BASE 20'h80000
`define PMW_U_C1_DATA_END 20'h9fffc
`define PMW_U_C1_PRAM_BASE 20'hc0000
`define PMW_U_C1_PRAM_END 20'hcfffc
`define PMW_U_C1_PROM_BASE 20'hd0000
`define PMW_U_C1_PROM_END 20'hd3ffc
// packed window (two locations per dword)
`define PMW_P_C0_DATA_END 20'h17ffc
// data ram block strides, as shifts of the byte offset
`define PMW_DSTRIDE_SHIFT 16
`define PMW_PSTRIDE_SHIFT 15
`endif

// file: pmw_pkg.sv
package pmw_pkg;
  typedef enum logic [2:0] {
    PMW_RG_NONE,
    PMW_RG_C0_DATA,
    PMW_RG_C0_PRAM,
    PMW_RG_C0_PROM,
    PMW_RG_C1_DATA,
    PMW_RG_C1_PRAM,
    PMW_RG_C1_PROM
  } pmw_region_t;
endpackage : pmw_pkg

// file: pmw_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmw_cfg.svh"
// Operation
// RULE_01 - unpacked window: one DSP location per dword, locations four bytes apart
// RULE_02 - unpacked 16-bit data: bits 15..8 lane 2, bits 7..0 lane 1
// RULE_03 - unpacked 24-bit program: lanes 2,1,0 carry bits 23..0, lane 3 unused
// RULE_04 - unpacked: first core data RAM blocks 0..3 at 64 KB strides from zero
// RULE_05 - unpacked: first core program RAM at 0x40000..0x4fffc, 24-bit layout
// RULE_06 - unpacked: first core ROM 0x50000..0x53ffc, then reserved to second core
// RULE_07 - unpacked: second core data blocks 0,1 at 0x80000 and 0x90000
// RULE_08 - unpacked: second core program RAM 0xc0000..0xcfffc, 24-bit layout
// RULE_09 - unpacked: second core ROM 0xd0000..0xd3ffc, rest of 1 MB reserved
// RULE_10 - packed: two 16-bit words per dword, high byte on upper lane
// RULE_11 - packed: first core data blocks 0..2 at 32 KB strides, end 0x17ffc
// RULE_12 - packed access to 24-bit memory moves upper 16 bits only
// RULE_13 - claim accesses only while memory-space enable is set
// RULE_14 - reserved reads zero, writes dropped; ROM and unused lanes not written
// RULE_15 - packed: lower location on lanes 1..0, next on lanes 3..2
module pmw_decode #(
  parameter int AW = 20,
  parameter int MW = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mem_en,
  input wire logic req,
  input wire logic packed_sel,
  input wire logic wr,
  input wire logic [AW-1:0] offset,
  input wire logic [3:0] byte_en,
  input wire logic [31:0] wdata,
  output logic claim,
  output logic ack,
  output logic [31:0] rdata,
  output logic mem_req,
  output logic mem_wr,
  output logic [2:0] mem_region,
  output logic [MW-1:0] mem_index,
  output logic mem_pair,
  output logic [23:0] mem_wdata,
  output logic [2:0] mem_bytesel,
  input wire logic mem_ack,
  input wire logic [23:0] mem_rdata0,
  input wire logic [23:0] mem_rdata1
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  pmw_pkg::pmw_region_t rg;
  logic [MW-1:0] idx;
  logic wide;
  logic rom;

  always_comb begin
    rg = pmw_pkg::PMW_RG_NONE;
    idx = '0;
    if (!packed_sel) begin
      idx = MW'(offset[AW-1:2]); // RULE_01
      if (offset <= `PMW_U_C0_DATA_END) begin
        rg = pmw_pkg::PMW_RG_C0_DATA; // RULE_04
      end else if (offset >= `PMW_U_C0_PRAM_BASE && offset <= `PMW_U_C0_PRAM_END) begin
        rg = pmw_pkg::PMW_RG_C0_PRAM; // RULE_05
      end else if (offset >= `PMW_U_C0_PROM_BASE && offset <= `PMW_U_C0_PROM_END) begin
        rg = pmw_pkg::PMW_RG_C0_PROM; // RULE_06
      end else if (offset >= `PMW_U_C1_DATA_BASE && offset <= `PMW_U_C1_DATA_END) begin
        rg = pmw_pkg::PMW_RG_C1_DATA; // RULE_07
      end else if (offset >= `PMW_U_C1_PRAM_BASE && offset <= `PMW_U_C1_PRAM_END) begin
        rg = pmw_pkg::PMW_RG_C1_PRAM; // RULE_08
      end else if (offset >= `PMW_U_C1_PROM_BASE && offset <= `PMW_U_C1_PROM_END) begin
        rg = pmw_pkg::PMW_RG_C1_PROM; // RULE_09
      end
    end else begin
      // each dword holds two locations: index of the lower one, the upper one for a lanes 3..2 write
      idx = MW'({offset[AW-1:2], (wr && byte_en[1:0] == 2'h0)}); // RULE_11 RULE_15
      if (offset <= `PMW_P_C0_DATA_END) begin
        rg = pmw_pkg::PMW_RG_C0_DATA; // RULE_11
      end
    end
  end

  assign wide = (rg == pmw_pkg::PMW_RG_C0_PRAM) || (rg == pmw_pkg::PMW_RG_C0_PROM) ||
                (rg == pmw_pkg::PMW_RG_C1_PRAM) || (rg == pmw_pkg::PMW_RG_C1_PROM);
  assign rom = (rg == pmw_pkg::PMW_RG_C0_PROM) || (rg == pmw_pkg::PMW_RG_C1_PROM);

  // ----------------------------------------------------------------
  // transfer control
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PMW_IDLE, PMW_WAIT, PMW_DONE} pmw_state_t;
  pmw_state_t state_r;
  logic hit;

  assign claim = req && mem_en && state_r == PMW_IDLE; // RULE_13
  assign hit = rg != pmw_pkg::PMW_RG_NONE;

  // lanes written per layout; rom and unused lanes are never written
  logic [2:0] bsel;
  logic [23:0] wlay;
  always_comb begin
    bsel = 3'h0;
    wlay = 24'h0;
    if (packed_sel) begin
      // one word per access: lanes 1..0 win over lanes 3..2
      if (byte_en[1:0] != 2'h0) begin
        wlay = {8'h0, wdata[15:0]}; // RULE_15
        bsel = {1'b0, byte_en[1], byte_en[0]};
      end else begin
        wlay = {8'h0, wdata[31:16]}; // RULE_10
        bsel = {1'b0, byte_en[3], byte_en[2]};
      end
      // wide memory takes the word in its upper sixteen bits
      if (wide) begin
        wlay = {wlay[15:0], 8'h0}; // RULE_12
        bsel = {bsel[1:0], 1'b0};
      end
    end else if (wide) begin
      wlay = wdata[23:0]; // RULE_03
      bsel = byte_en[2:0];
    end else begin
      wlay = {8'h0, wdata[23:8]}; // RULE_02
      bsel = {1'b0, byte_en[2:1]};
    end
    if (rom) begin
      bsel = 3'h0; // RULE_14
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PMW_IDLE;
    end else begin
      case (state_r)
        PMW_IDLE: if (claim) state_r <= hit ? PMW_WAIT : PMW_DONE; // RULE_14
        PMW_WAIT: if (mem_ack) state_r <= PMW_DONE;
        PMW_DONE: state_r <= PMW_IDLE;
        default: state_r <= PMW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_region <= 3'h0;
      mem_index <= '0;
      mem_pair <= 1'b0;
      mem_wdata <= 24'h0;
      mem_bytesel <= 3'h0;
    end else begin
      if (state_r == PMW_IDLE && claim && hit) begin
        mem_req <= 1'b1;
        mem_wr <= wr;
        mem_region <= rg;
        mem_index <= idx;
        mem_pair <= packed_sel;
        mem_wdata <= wlay;
        mem_bytesel <= bsel;
      end else if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data steering
  // ----------------------------------------------------------------
  logic [31:0] rlay;
  always_comb begin
    rlay = 32'h0;
    if (mem_pair) begin
      // wide memory: only the upper sixteen bits travel
      rlay = {mem_rdata1[23:8], mem_rdata0[23:8]}; // RULE_12
      if (mem_region == pmw_pkg::PMW_RG_C0_DATA || mem_region == pmw_pkg::PMW_RG_C1_DATA) begin
        rlay = {mem_rdata1[15:0], mem_rdata0[15:0]}; // RULE_15
      end
    end else if (mem_region == pmw_pkg::PMW_RG_C0_DATA || mem_region == pmw_pkg::PMW_RG_C1_DATA) begin
      rlay = {8'h0, mem_rdata0[15:0], 8'h0}; // RULE_02
    end else begin
      rlay = {8'h0, mem_rdata0}; // RULE_03
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (state_r == PMW_IDLE && claim && !hit) begin
      rdata <= 32'h0; // RULE_14
    end else if (state_r == PMW_WAIT && mem_ack) begin
      rdata <= mem_wr ? 32'h0 : rlay;
    end
  end

  assign ack = state_r == PMW_DONE;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_claim_gated: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_13
    state_r == PMW_IDLE && !mem_en |-> !claim ##1 state_r == PMW_IDLE && !mem_req)
    else $error("claim without memory enable");
  a_rom_nowrite: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_req && (mem_region == 3'(pmw_pkg::PMW_RG_C0_PROM) || mem_region == 3'(pmw_pkg::PMW_RG_C1_PROM))
    |-> mem_bytesel == 3'h0) else $error("rom lane write"); // RULE_14
  a_resv_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == PMW_IDLE && claim && !hit |=> ack && rdata == 32'h0) else $error("reserved not zero"); // RULE_14
  a_unp_lane3: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ack && !mem_pair |-> rdata[31:24] == 8'h0) else $error("lane 3 used"); // RULE_03
  a_c1_prom: assert property (@(posedge clk_sys) disable iff (!rst_n)
    claim && !packed_sel && offset == `PMW_U_C1_PROM_END |=> mem_region == 3'(pmw_pkg::PMW_RG_C1_PROM))
    else $error("second core rom miss"); // RULE_09
  a_c0_pram: assert property (@(posedge clk_sys) disable iff (!rst_n)
    claim && state_r == PMW_IDLE && !packed_sel && offset == `PMW_U_C0_PRAM_BASE
    |=> mem_req && mem_region == 3'(pmw_pkg::PMW_RG_C0_PRAM) && mem_index == MW'(16'h0)) else $error("pram"); // RULE_05
  a_pk_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    claim && state_r == PMW_IDLE && packed_sel && offset > `PMW_P_C0_DATA_END |=> !mem_req && ack)
    else $error("packed beyond map"); // RULE_11
  a_unp_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    claim && state_r == PMW_IDLE && hit && !packed_sel |=> mem_index == MW'($past(offset) >> 2))
    else $error("index not dword"); // RULE_01
  a_pk_lower: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
    claim && state_r == PMW_IDLE && hit && packed_sel && !wr |=> mem_req && mem_pair && !mem_index[0])
    else $error("packed read not at lower location");
  c_pk_read: cover property (@(posedge clk_sys) ack && mem_pair && !mem_wr);
  c_pk_write: cover property (@(posedge clk_sys) ack && mem_pair && mem_wr);
  c_unp_write: cover property (@(posedge clk_sys) ack && !mem_pair && mem_wr);
  c_resv: cover property (@(posedge clk_sys) claim && !hit);
endmodule : pmw_decode
`default_nettype wire

// file: pmw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] dly,
  input wire logic mem_req,
  input wire logic [2:0] mem_region,
  input wire logic [15:0] mem_index,
  output logic mem_ack,
  output logic [23:0] mem_rdata0,
  output logic [23:0] mem_rdata1
);
  logic [3:0] cnt_r;
  function automatic logic [23:0] pat(logic [2:0] rg, logic [15:0] i);
    return {(rg inside {3'h2, 3'h3, 3'h5, 3'h6}) ? i[7:0] ^ 8'hc3 : 8'h00, i ^ 16'h5aa5};
  endfunction : pat
  // data is only valid with the acknowledge
  assign mem_rdata0 = mem_ack ? pat(mem_region, mem_index) : ~pat(mem_region, mem_index);
  assign mem_rdata1 = mem_ack ? pat(mem_region, mem_index + 16'h1) : ~pat(mem_region, mem_index);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b0;
    end else begin
      mem_ack <= mem_req && !mem_ack && cnt_r >= dly;
      cnt_r <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : pmw_mem_model
`default_nettype wire

// file: pci_dsp_memory_window_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module pci_dsp_memory_window_decode_test;
  logic clk_sys, rst_n, mem_en, req, packed_sel, wr, claim, ack, mem_req, mem_wr, mem_pair, mem_ack;
  logic [19:0] offset;
  logic [3:0] byte_en, dly;
  logic [31:0] wdata, rdata, e;
  logic [2:0] mem_region, mem_bytesel, bs;
  logic [15:0] mem_index;
  logic [23:0] mem_wdata, mem_rdata0, mem_rdata1, wd;
  int error_cnt, n_compared, cyc;
  pmw_decode DUT (.clk_sys, .rst_n, .mem_en, .req, .packed_sel, .wr, .offset, .byte_en, .wdata, .claim, .ack,
    .rdata, .mem_req, .mem_wr, .mem_region, .mem_index, .mem_pair, .mem_wdata, .mem_bytesel, .mem_ack,
    .mem_rdata0, .mem_rdata1);
  pmw_mem_model mdl (.clk_sys, .rst_n, .dly, .mem_req, .mem_region, .mem_index, .mem_ack, .mem_rdata0,
    .mem_rdata1);
  // memory contents as the partner model presents them
  function automatic logic [23:0] pat(logic [2:0] rg, logic [15:0] i);
    return {(rg inside {3'h2, 3'h3, 3'h5, 3'h6}) ? i[7:0] ^ 8'hc3 : 8'h00, i ^ 16'h5aa5};
  endfunction : pat
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic acc(logic pk, logic w, logic [19:0] off, logic [31:0] exp, logic [2:0] rg, logic [15:0] ix);
    logic seen;
    logic [2:0] r;
    logic [15:0] x;
    seen = 1'b0;
    @(posedge clk_sys);
    #1;
    packed_sel = pk;
    wr = w;
    offset = off;
    req = 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      if (mem_req) begin
        seen = 1'b1;
        r = mem_region;
        x = mem_index;
        bs = mem_bytesel;
        wd = mem_wdata;
      end
      if (ack === 1'b1) break;
    end
    chk("ack", 32'h1, {31'h0, ack});
    if (!w) chk("rdata", exp, rdata);
    chk("mem_req seen", {31'h0, rg != 3'h0}, {31'h0, seen});
    if (seen) chk("region", {29'h0, rg}, {29'h0, r});
    if (seen) chk("index", {16'h0, ix}, {16'h0, x});
    @(posedge clk_sys);
    #1;
    req = 1'b0;
  endtask : acc
  task automatic t_unpacked();
    logic [19:0] offs[13] = '{20'h0, 20'h3fffc, 20'h40000, 20'h4fffc, 20'h53ffc, 20'h54000, 20'h80000,
      20'h9fffc, 20'ha0000, 20'hc0000, 20'hd3ffc, 20'hd4000, 20'hffffc};
    logic [2:0] rgs[13] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h0, 3'h4, 3'h4, 3'h0, 3'h5, 3'h6, 3'h0, 3'h0};
    logic [15:0] ixs[13] = '{16'h0, 16'hffff, 16'h0, 16'h3fff, 16'h4fff, 16'h0, 16'h0, 16'h7fff, 16'h0, 16'h0,
      16'h4fff, 16'h0, 16'h0};
    for (int i = 0; i < 13; i++) begin
      dly = i[0] ? 4'h5 : 4'h0;
      e = {8'h0, pat(rgs[i], ixs[i])};
      if (rgs[i] inside {3'h1, 3'h4}) e = {e[23:0], 8'h0};
      if (rgs[i] == 3'h0) e = 32'h0;
      acc(1'b0, 1'b0, offs[i], e, rgs[i], ixs[i]);
    end
    $display("unpacked map done");
  endtask : t_unpacked
  task automatic t_packed();
    logic [23:0] lo, hi;
    lo = pat(3'h1, 16'h0);
    hi = pat(3'h1, 16'h1);
    e = {hi[15:0], lo[15:0]};
    acc(1'b1, 1'b0, 20'h0, e, 3'h1, 16'h0);
    lo = pat(3'h1, 16'hbffe);
    hi = pat(3'h1, 16'hbfff);
    e = {hi[15:0], lo[15:0]};
    acc(1'b1, 1'b0, 20'h17ffc, e, 3'h1, 16'hbffe);
    acc(1'b1, 1'b0, 20'h18000, 32'h0, 3'h0, 16'h0);
    $display("packed map done");
  endtask : t_packed
  task automatic t_write();
    wdata = 32'h00abcd00;
    acc(1'b0, 1'b1, 20'h4, 0, 3'h1, 16'h1);
    chk("bytesel", 32'h3, {29'h0, bs});
    chk("wdata", 32'habcd, {16'h0, wd[15:0]});
    acc(1'b0, 1'b1, 20'h50000, 0, 3'h3, 16'h4000);
    chk("rom bytesel", 32'h0, {29'h0, bs});
    acc(1'b0, 1'b1, 20'h54000, 0, 3'h0, 16'h0);
    wdata = 32'h1234abcd;
    byte_en = 4'h3;
    acc(1'b1, 1'b1, 20'h8, 0, 3'h1, 16'h4);
    chk("packed low bytesel", 32'h3, {29'h0, bs});
    chk("packed low wdata", 32'habcd, {16'h0, wd[15:0]});
    byte_en = 4'hc;
    acc(1'b1, 1'b1, 20'h8, 0, 3'h1, 16'h5);
    chk("packed high bytesel", 32'h3, {29'h0, bs});
    chk("packed high wdata", 32'h1234, {16'h0, wd[15:0]});
    byte_en = 4'hf;
    $display("writes done");
  endtask : t_write
  task automatic t_memen();
    @(posedge clk_sys);
    #1;
    mem_en = 1'b0;
    req = 1'b1;
    repeat (4) begin
      @(negedge clk_sys);
      chk("claim off", 32'h0, {30'h0, claim, ack});
    end
    @(posedge clk_sys);
    #1;
    req = 1'b0;
    mem_en = 1'b1;
    $display("enable done");
  endtask : t_memen
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    {rst_n, req, packed_sel, wr, offset, wdata, dly} = '0;
    mem_en = 1'b1;
    byte_en = 4'hf;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_unpacked();
    t_packed();
    t_write();
    t_memen();
    t_unpacked();
    results();
  end
endmodule : pci_dsp_memory_window_decode_test
`default_nettype wire
